// ==== hdl/lfp_defines.svh ====
/*
  Address map, field positions, error codes and sizes of the logger
  file-policy block.
  Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
*/
`ifndef LFP_DEFINES_SVH
`define LFP_DEFINES_SVH

`define LFP_AW 12
`define LFP_A_CTRL 12'h000
`define LFP_A_STS 12'h004
`define LFP_A_MASK 12'h008
`define LFP_A_IEN 12'h00c
`define LFP_A_TIME 12'h010
`define LFP_A_DATE 12'h014
`define LFP_A_FLAGS 12'h018
`define LFP_A_ERR 12'h01c
`define LFP_FILE_PAGE 6'h01
`define LFP_RAM_PAGE 4'h1
`define LFP_NVM_PAGE 4'h2
`define LFP_RAM_WORDS 5'h0e
`define LFP_NVM_WORDS 5'h10
`define LFP_NVM_BASE_IDX 5'h10

`define LFP_CTRL_WP 0
`define LFP_CTRL_ESC 1
`define LFP_STS_RUN 0
`define LFP_STS_DROP 1
`define LFP_STS_ACCERR 2
`define LFP_STS_TIME 3

`define LFP_ERR_NONE 8'h00
`define LFP_ERR_NOFILE 8'h01
`define LFP_ERR_SECTOR 8'h02
`define LFP_ERR_LENGTH 8'h03

`define LFP_SECTOR_BYTES 17'h00200
`define LFP_RESP_OKAY 2'h0
`define LFP_RESP_SLVERR 2'h2

`endif

// ==== hdl/lfp_pkg.sv ====
/*
  Types of the logger file-policy block.
  Assumes lfp_defines.svh is on the include path.
*/
package lfp_pkg;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} lfp_rd_t;

  typedef enum logic {ENTRY_INIT, ENTRY_EVENT} lfp_entry_t;

  typedef struct packed {
    logic aw_ok;
    logic [11:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    lfp_rd_t rd_st;
    logic [11:0] araddr;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wp;
    logic esc_en;
    logic [3:0] sts;
    logic [3:0] mask;
    logic [3:0] ien;
    logic [31:0] time_v;
    logic [31:0] date_v;
    logic [7:0] err;
    logic [3:0][31:0] fbase;
    logic [3:0][15:0] flen;
    logic [3:0][15:0] fhdr;
    logic [3:0][15:0] fptr;
    logic [3:0] irq_prev;
    logic tick_prev;
    logic [4:0] pend;
    logic init_done;
    logic busy;
    logic run_req;
    lfp_entry_t run_entry;
    logic [4:0] run_cause;
    logic host_ack;
    logic host_commit;
    logic acc_done;
    logic acc_err;
    logic [31:0] acc_addr;
    logic lut_ack;
    logic lut_out;
    logic [7:0] lut_data;
  } lfp_state_t;

endpackage

// ==== hdl/lfp_sync.sv ====
/*
  Three-stage synchroniser for pins from outside the clock domain.
  The output only moves once the second and third stages agree, which
  filters a single-cycle glitch at the cost of one more cycle of delay.
*/
`timescale 1ns/1ns
module lfp_sync #(
  parameter int W = 6
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } lfp_sync_t;

  lfp_sync_t q_ff, nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = pin_in;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.lvl[i] = q_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign level_out = q_ff.lvl;
endmodule

// ==== hdl/lfp_mem.sv ====
/*
  Small word memory for working RAM and the non-volatile byte store.
  Byte strobes let software use 1, 2 or 4 byte values; read data are
  registered, so a read address shows its data one cycle later.
*/
`timescale 1ns/1ns
module lfp_mem (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic we_in,
  input wire logic [4:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic [4:0] raddr_in,
  output logic [31:0] rdata_out
);
  typedef struct packed {
    logic [31:0][31:0] mem;
    logic [31:0] rdata;
  } lfp_mem_t;

  lfp_mem_t q_ff, nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.rdata = q_ff.mem[raddr_in];
    if (we_in) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_in[b]) begin
          nxt_q.mem[waddr_in][8*b +: 8] = wdata_in[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rdata_out = q_ff.rdata;
endmodule

// ==== hdl/lfp_top.sv ====
/*
  Storage-access policy and event dispatch of a mass-storage data logger:
  AXI4-Lite registers, host modification gate, four file pointers,
  event dispatch, working RAM, non-volatile store and constant table.
  Assumes one 100 MHz clock; host, file-access and table ports are
  driven from logic on the same clock, pins pass lfp_sync.
*/
`timescale 1ns/1ns
`include "lfp_defines.svh"

// What this block does
// - Write protect blocks host changes, permanently set
// - Protected host changes still reported as successful
// - Escape pin overrides write protect
// - Root file change loads clock from timestamp
// - Clock tick or interrupt starts application code
// - Separate init entry and event entry
// - Clear interrupt enable before dispatching
// - At most four files accessible
// - Device never creates, deletes or resizes files
// - Pointer wraps to start past header
// - Working RAM usable as 1/2/4 byte values
// - Status block: flags, error, time, date
// - Non-volatile byte store, read and write
// - Constants readable only by table instructions
module lfp_top (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic escape_pin_in,
  input wire logic rtc_tick_pin_in,
  input wire logic [3:0] irq_pin_in,
  input wire logic host_mod_valid_in,
  input wire logic host_root_in,
  input wire logic [31:0] host_time_in,
  input wire logic [31:0] host_date_in,
  output logic host_ack_out,
  output logic host_commit_out,
  input wire logic acc_valid_in,
  input wire logic [1:0] acc_file_in,
  input wire logic [9:0] acc_len_in,
  output logic acc_done_out,
  output logic acc_err_out,
  output logic [31:0] acc_addr_out,
  input wire logic lut_valid_in,
  input wire logic lut_write_out_in,
  input wire logic [3:0] lut_addr_in,
  output logic lut_ack_out,
  output logic lut_to_file_out,
  output logic [7:0] lut_data_out,
  input wire logic app_done_in,
  output logic run_req_out,
  output lfp_pkg::lfp_entry_t run_entry_out,
  output logic [4:0] run_cause_out,
  output logic irq_out
);
  import lfp_pkg::*;

  lfp_state_t q_ff, nxt_q;
  logic [5:0] pins_s;
  logic esc_s;
  logic tick_s;
  logic [3:0] irq_s;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [4:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic allowed;
  logic [3:0] irq_rise;
  logic [4:0] new_ev;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Maps a byte address in the RAM or store pages to a word index.
  function automatic logic [5:0] mem_index(input logic [11:0] a);
    logic [4:0] w;
    w = {1'b0, a[5:2]};
    if (a[11:8] == `LFP_RAM_PAGE && a[7:6] == 2'h0 &&
        w < `LFP_RAM_WORDS) begin
      return {1'b1, w};
    end else if (a[11:8] == `LFP_NVM_PAGE && a[7:6] == 2'h0) begin
      return {1'b1, w | `LFP_NVM_BASE_IDX};
    end
    return 6'h00;
  endfunction

  // The table sits in program space; only the table port reaches it.
  function automatic logic [7:0] table_rom(input logic [3:0] a);
    logic [7:0] v;
    case (a)
      4'h0: v = 8'h01;
      4'h1: v = 8'h02;
      4'h2: v = 8'h04;
      4'h3: v = 8'h08;
      4'h4: v = 8'h10;
      4'h5: v = 8'h20;
      4'h6: v = 8'h40;
      4'h7: v = 8'h80;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  lfp_sync #(
    .W(6)
  ) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pin_in({irq_pin_in, rtc_tick_pin_in, escape_pin_in}),
    .level_out(pins_s)
  );

  assign esc_s = pins_s[0];
  assign tick_s = pins_s[1];
  assign irq_s = pins_s[5:2];

  lfp_mem u_mem (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(q_ff.wdata),
    .wstrb_in(q_ff.wstrb),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  logic do_wr;
  logic [5:0] wr_idx, rd_idx, ar_idx;
  assign do_wr = q_ff.aw_ok && q_ff.w_ok && !q_ff.bvalid;
  assign wr_idx = mem_index(q_ff.awaddr);
  assign rd_idx = mem_index(q_ff.araddr);
  assign ar_idx = mem_index(s_axi_araddr_in);
  assign mem_we = do_wr && wr_idx[5];
  assign mem_waddr = wr_idx[4:0];
  // The memory registers its data, so the address is offered while the
  // request is still on the bus; otherwise a read returns stale words.
  assign mem_raddr = (q_ff.rd_st == RD_IDLE) ? ar_idx[4:0] : rd_idx[4:0];
  assign allowed = !q_ff.wp || (q_ff.esc_en && esc_s);
  assign irq_rise = irq_s & ~q_ff.irq_prev & q_ff.ien;
  assign new_ev = {tick_s && !q_ff.tick_prev, irq_rise};

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic [1:0] f;
    logic [15:0] off;
    logic [16:0] end_pos;
    logic [16:0] sec_end;
    logic ok_addr;
    wv = 32'h0;
    rv = 32'h0;
    f = acc_file_in;
    off = q_ff.fptr[acc_file_in];
    end_pos = {1'b0, off} + {7'h00, acc_len_in};
    sec_end = {8'h00, off[8:0]} + {7'h00, acc_len_in};
    ok_addr = 1'b0;
    nxt_q = q_ff;
    nxt_q.run_req = 1'b0;
    nxt_q.host_ack = 1'b0;
    nxt_q.host_commit = 1'b0;
    nxt_q.acc_done = 1'b0;
    nxt_q.acc_err = 1'b0;
    nxt_q.lut_ack = 1'b0;
    nxt_q.irq_prev = irq_s;
    nxt_q.tick_prev = tick_s;

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      nxt_q.aw_ok = 1'b1;
      nxt_q.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      nxt_q.w_ok = 1'b1;
      nxt_q.wdata = s_axi_wdata_in;
      nxt_q.wstrb = s_axi_wstrb_in;
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      nxt_q.bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_q.aw_ok = 1'b0;
      nxt_q.w_ok = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = `LFP_RESP_OKAY;
      wv = q_ff.wdata;
      case (q_ff.awaddr)
        `LFP_A_CTRL: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.wp = q_ff.wp | wv[`LFP_CTRL_WP];
            nxt_q.esc_en = wv[`LFP_CTRL_ESC];
          end
        end
        `LFP_A_STS: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.sts = q_ff.sts & ~wv[3:0];
          end
        end
        `LFP_A_MASK: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.mask = wv[3:0];
          end
        end
        `LFP_A_IEN: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.ien = wv[3:0];
          end
        end
        `LFP_A_TIME: nxt_q.time_v = merge(q_ff.time_v, wv, q_ff.wstrb);
        `LFP_A_DATE: nxt_q.date_v = merge(q_ff.date_v, wv, q_ff.wstrb);
        `LFP_A_FLAGS, `LFP_A_ERR: begin
        end
        default: begin
          if (q_ff.awaddr[11:6] == `LFP_FILE_PAGE) begin
            // Base and length describe a file the host already made.
            case (q_ff.awaddr[3:2])
              2'h0: nxt_q.fbase[q_ff.awaddr[5:4]] =
                  merge(q_ff.fbase[q_ff.awaddr[5:4]], wv, q_ff.wstrb);
              2'h1: nxt_q.flen[q_ff.awaddr[5:4]] = wv[15:0];
              2'h2: nxt_q.fhdr[q_ff.awaddr[5:4]] = wv[15:0];
              default: nxt_q.fptr[q_ff.awaddr[5:4]] = wv[15:0];
            endcase
          end else if (!wr_idx[5]) begin
            nxt_q.bresp = `LFP_RESP_SLVERR;
          end
        end
      endcase
    end

    // Read channel: memory data are registered, so reads take a wait.
    case (q_ff.rd_st)
      RD_IDLE: begin
        if (s_axi_arvalid_in) begin
          nxt_q.araddr = s_axi_araddr_in;
          nxt_q.rd_st = RD_WAIT;
        end
      end
      RD_WAIT: begin
        ok_addr = 1'b1;
        case (q_ff.araddr)
          `LFP_A_CTRL: rv = {30'h0, q_ff.esc_en, q_ff.wp};
          `LFP_A_STS: rv = {28'h0, q_ff.sts};
          `LFP_A_MASK: rv = {28'h0, q_ff.mask};
          `LFP_A_IEN: rv = {28'h0, q_ff.ien};
          `LFP_A_TIME: rv = q_ff.time_v;
          `LFP_A_DATE: rv = q_ff.date_v;
          `LFP_A_FLAGS: rv = {27'h0, q_ff.busy, q_ff.init_done,
                              esc_s, allowed, q_ff.wp};
          `LFP_A_ERR: rv = {24'h0, q_ff.err};
          default: begin
            if (q_ff.araddr[11:6] == `LFP_FILE_PAGE) begin
              case (q_ff.araddr[3:2])
                2'h0: rv = q_ff.fbase[q_ff.araddr[5:4]];
                2'h1: rv = {16'h0, q_ff.flen[q_ff.araddr[5:4]]};
                2'h2: rv = {16'h0, q_ff.fhdr[q_ff.araddr[5:4]]};
                default: rv = {16'h0, q_ff.fptr[q_ff.araddr[5:4]]};
              endcase
            end else if (rd_idx[5]) begin
              rv = mem_rdata;
            end else begin
              ok_addr = 1'b0;
            end
          end
        endcase
        nxt_q.rdata = rv;
        nxt_q.rresp = ok_addr ? `LFP_RESP_OKAY : `LFP_RESP_SLVERR;
        nxt_q.rd_st = RD_RESP;
      end
      RD_RESP: begin
        if (s_axi_rready_in) begin
          nxt_q.rd_st = RD_IDLE;
        end
      end
      default: nxt_q.rd_st = RD_IDLE;
    endcase

    // Hardware clears an enable after the software write of this cycle.
    nxt_q.ien = nxt_q.ien & ~irq_rise;
    nxt_q.pend = q_ff.pend | new_ev;
    if (app_done_in) begin
      nxt_q.busy = 1'b0;
    end
    if (!q_ff.busy) begin
      if (!q_ff.init_done) begin
        nxt_q.init_done = 1'b1;
        nxt_q.busy = 1'b1;
        nxt_q.run_req = 1'b1;
        nxt_q.run_entry = ENTRY_INIT;
        nxt_q.run_cause = 5'h00;
      end else if (q_ff.pend != 5'h00) begin
        nxt_q.busy = 1'b1;
        nxt_q.run_req = 1'b1;
        nxt_q.run_entry = ENTRY_EVENT;
        nxt_q.run_cause = q_ff.pend;
        nxt_q.pend = new_ev;
        nxt_q.sts[`LFP_STS_RUN] = 1'b1;
      end
    end

    if (host_mod_valid_in) begin
      nxt_q.host_ack = 1'b1;
      nxt_q.host_commit = allowed;
      if (!allowed) begin
        nxt_q.sts[`LFP_STS_DROP] = 1'b1;
      end
      if (host_root_in) begin
        nxt_q.time_v = host_time_in;
        nxt_q.date_v = host_date_in;
        nxt_q.sts[`LFP_STS_TIME] = 1'b1;
      end
    end

    // No path here alters base or length; a missing file is an error.
    if (acc_valid_in) begin
      nxt_q.acc_done = 1'b1;
      if (q_ff.flen[f] == 16'h0000 || acc_len_in == 10'h000) begin
        nxt_q.acc_err = 1'b1;
        nxt_q.err = `LFP_ERR_NOFILE;
      end else if (sec_end > `LFP_SECTOR_BYTES) begin
        nxt_q.acc_err = 1'b1;
        nxt_q.err = `LFP_ERR_SECTOR;
      end else if (end_pos > {1'b0, q_ff.flen[f]}) begin
        nxt_q.acc_err = 1'b1;
        nxt_q.err = `LFP_ERR_LENGTH;
      end else begin
        nxt_q.acc_addr = q_ff.fbase[f] + {16'h0000, off};
        nxt_q.err = `LFP_ERR_NONE;
        if (end_pos >= {1'b0, q_ff.flen[f]}) begin
          nxt_q.fptr[f] = q_ff.fhdr[f];
        end else begin
          nxt_q.fptr[f] = end_pos[15:0];
        end
      end
      if (nxt_q.acc_err) begin
        nxt_q.sts[`LFP_STS_ACCERR] = 1'b1;
      end
    end

    if (lut_valid_in) begin
      nxt_q.lut_ack = 1'b1;
      nxt_q.lut_out = lut_write_out_in;
      nxt_q.lut_data = table_rom(lut_addr_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_awready_out = !q_ff.aw_ok && !q_ff.bvalid;
  assign s_axi_wready_out = !q_ff.w_ok && !q_ff.bvalid;
  assign s_axi_bvalid_out = q_ff.bvalid;
  assign s_axi_bresp_out = q_ff.bresp;
  assign s_axi_arready_out = q_ff.rd_st == RD_IDLE;
  assign s_axi_rvalid_out = q_ff.rd_st == RD_RESP;
  assign s_axi_rdata_out = q_ff.rdata;
  assign s_axi_rresp_out = q_ff.rresp;
  assign host_ack_out = q_ff.host_ack;
  assign host_commit_out = q_ff.host_commit;
  assign acc_done_out = q_ff.acc_done;
  assign acc_err_out = q_ff.acc_err;
  assign acc_addr_out = q_ff.acc_addr;
  assign lut_ack_out = q_ff.lut_ack;
  assign lut_to_file_out = q_ff.lut_out;
  assign lut_data_out = q_ff.lut_data;
  assign run_req_out = q_ff.run_req;
  assign run_entry_out = q_ff.run_entry;
  assign run_cause_out = q_ff.run_cause;
  assign irq_out = |(q_ff.sts & q_ff.mask);
endmodule

// ==== bench/lfp_host_model.sv ====
/*
  Model of the PC that edits files on the logger's disk.
  Assumes the bench calls modify() and that clk_in is the block's clock.
*/
`timescale 1ns/1ns
module lfp_host_model (
  input wire logic clk_in,
  output logic host_mod_valid_out,
  output logic host_root_out,
  output logic [31:0] host_time_out,
  output logic [31:0] host_date_out
);
  initial begin
    host_mod_valid_out = 1'b0;
    host_root_out = 1'b0;
    host_time_out = 32'h0;
    host_date_out = 32'h0;
  end
  // After the pulse the qualifiers carry inverted junk, so that the block
  // cannot lean on stale timestamps.
  task automatic modify(input logic r, input logic [31:0] t,
                        input logic [31:0] d);
    @(posedge clk_in);
    host_mod_valid_out <= 1'b1;
    host_root_out <= r;
    host_time_out <= t;
    host_date_out <= d;
    @(posedge clk_in);
    host_mod_valid_out <= 1'b0;
    host_root_out <= ~r;
    host_time_out <= ~t;
    host_date_out <= ~d;
  endtask
endmodule

// ==== bench/lfp_top_monitor.sv ====
/*
  Checker of the port behaviour of the logger file-policy block.
  Assumes it is bound to lfp_top and sees only its ports.
*/
`timescale 1ns/1ns
module lfp_top_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic host_mod_valid_in,
  input wire logic host_ack_out,
  input wire logic host_commit_out,
  input wire logic acc_valid_in,
  input wire logic acc_done_out,
  input wire logic acc_err_out,
  input wire logic lut_valid_in,
  input wire logic lut_write_out_in,
  input wire logic [3:0] lut_addr_in,
  input wire logic lut_ack_out,
  input wire logic [7:0] lut_data_out,
  input wire logic run_req_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  host_ack_a: assert property (host_mod_valid_in |=> host_ack_out)
    else $error("host edit not acknowledged");
  ack_cause_a: assert property (host_ack_out |-> $past(host_mod_valid_in))
    else $error("acknowledge without an edit");
  commit_ack_a: assert property (host_commit_out |-> host_ack_out)
    else $error("commit outside an acknowledge");
  acc_done_a: assert property (acc_valid_in |=> acc_done_out)
    else $error("file access not completed");
  acc_err_a: assert property (acc_err_out |-> acc_done_out)
    else $error("access error without completion");
  lut_data_a: assert property (lut_valid_in && !lut_write_out_in |=>
    lut_ack_out && lut_data_out == (($past(lut_addr_in) < 4'h8) ?
    8'h01 << $past(lut_addr_in[2:0]) : 8'h00))
    else $error("table read data wrong");
  run_pulse_a: assert property (run_req_out |=> !run_req_out [*2])
    else $error("dispatch request not a pulse");
  bresp_hold_a: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  cover property (host_ack_out && !host_commit_out);
  cover property (acc_done_out && acc_err_out);
  cover property (run_req_out);
endmodule

bind lfp_top lfp_top_monitor lfp_top_monitor_i (.clk_in, .rst_b_in,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .s_axi_rdata_out, .host_mod_valid_in, .host_ack_out,
  .host_commit_out, .acc_valid_in, .acc_done_out, .acc_err_out,
  .lut_valid_in, .lut_write_out_in, .lut_addr_in, .lut_ack_out,
  .lut_data_out, .run_req_out);

// ==== bench/tb_top.sv ====
/*
  Self-checking bench of lfp_top with a host model beside it.
  Assumes lfp_defines.svh on the include path and a 100 MHz clock.
*/
`timescale 1ns/1ns
`include "lfp_defines.svh"
module tb_top;
  import lfp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] s_axi_awaddr_in = 12'h000;
  logic [11:0] s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out, acc_addr_out, host_time_in, host_date_in;
  logic escape_pin_in = 1'b0, rtc_tick_pin_in = 1'b0;
  logic [3:0] irq_pin_in = 4'h0;
  logic host_mod_valid_in, host_root_in, host_ack_out, host_commit_out;
  logic acc_valid_in = 1'b0, acc_done_out, acc_err_out;
  logic [1:0] acc_file_in = 2'h0;
  logic [9:0] acc_len_in = 10'h000;
  logic lut_valid_in = 1'b0, lut_write_out_in = 1'b0, lut_ack_out;
  logic [3:0] lut_addr_in = 4'h0;
  logic lut_to_file_out, app_done_in = 1'b0, run_req_out, irq_out;
  logic [7:0] lut_data_out;
  lfp_entry_t run_entry_out;
  logic [4:0] run_cause_out;
  logic [39:0] bq[$], rq[$], hq[$], aq[$], lq[$], dq[$];
  logic [31:0] t, d, v;
  logic wo;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  lfp_top lfp_top_i (.*);
  lfp_host_model lfp_host_model_i (
    .clk_in(clk_in),
    .host_mod_valid_out(host_mod_valid_in),
    .host_root_out(host_root_in),
    .host_time_out(host_time_in),
    .host_date_out(host_date_in)
  );
  task automatic conclude();
    chk("notes left", 40'h0, 40'(bq.size() + rq.size() + hq.size() +
        aq.size() + lq.size() + dq.size()));
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [39:0] e, logic [39:0] s);
    n_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  // An output with no note waiting is itself a fault, e.g. a stray dispatch.
  task automatic pop(string n, ref logic [39:0] q[$], input logic [39:0] s);
    if (q.size() == 0) chk(n, 40'h0, ~s);
    else chk(n, q.pop_front(), s);
  endtask
  always @(posedge clk_in) begin
    if (s_axi_bvalid_out && s_axi_bready_in)
      pop("bresp", bq, 40'(s_axi_bresp_out));
    if (s_axi_rvalid_out && s_axi_rready_in)
      pop("rdata", rq, 40'({s_axi_rresp_out, s_axi_rdata_out}));
    if (host_ack_out) pop("commit", hq, 40'(host_commit_out));
    if (acc_done_out)
      pop("access", aq, 40'({acc_err_out, acc_err_out ? 32'h0 : acc_addr_out}));
    if (lut_ack_out) pop("table", lq, 40'({lut_to_file_out, lut_data_out}));
    if (run_req_out) pop("dispatch", dq, 40'({run_entry_out, run_cause_out}));
  end
  task automatic wr(logic [11:0] a, logic [31:0] x, logic [3:0] s = 4'hf,
                    logic [1:0] r = 2'h0);
    logic aw_d;
    logic w_d;
    bq.push_back(40'(r));
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= x;
    s_axi_wstrb_in <= s;
    s_axi_wvalid_in <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_d = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_d = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    s_axi_bready_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x, logic [1:0] r = 2'h0);
    rq.push_back(40'({r, x}));
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic host(logic root, logic ok);
    hq.push_back(40'(ok));
    lfp_host_model_i.modify(root, t, d);
  endtask
  task automatic acc(logic [1:0] f, logic [9:0] n, logic e, logic [31:0] a);
    aq.push_back(40'({e, a}));
    @(posedge clk_in);
    acc_valid_in <= 1'b1;
    acc_file_in <= f;
    acc_len_in <= n;
    @(posedge clk_in);
    acc_valid_in <= 1'b0;
  endtask
  task automatic run_wait();
    for (int k = 0; k < 40 && !run_req_out; k++) @(posedge clk_in);
    chk("dispatch seen", 40'h1, 40'(run_req_out));
    @(posedge clk_in);
    app_done_in <= 1'b1;
    @(posedge clk_in);
    app_done_in <= 1'b0;
  endtask
  // The whole run needs a few hundred cycles; 30000 leaves ample margin.
  initial begin
    #300000;
    bad_count++;
    conclude();
  end
  initial begin
    t = $urandom(32'h6a4a);
    d = $urandom;
    dq.push_back(40'h0);
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    run_wait();
    rd(`LFP_A_CTRL, 32'h0);
    rd(12'h0f0, 32'h0, `LFP_RESP_SLVERR);
    wr(12'h0f0, 32'h1, 4'hf, `LFP_RESP_SLVERR);
    host(1'b1, 1'b1);
    rd(`LFP_A_TIME, t);
    rd(`LFP_A_DATE, d);
    wr(`LFP_A_CTRL, 32'h1);
    wr(`LFP_A_CTRL, 32'h0);
    rd(`LFP_A_CTRL, 32'h1);
    t = $urandom;
    host(1'b1, 1'b0);
    host(1'b0, 1'b0);
    rd(`LFP_A_TIME, t);
    wr(`LFP_A_MASK, 32'h2);
    @(posedge clk_in);
    chk("irq", 40'h1, 40'(irq_out));
    wr(`LFP_A_STS, 32'h2);
    @(posedge clk_in);
    chk("irq", 40'h0, 40'(irq_out));
    escape_pin_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    host(1'b0, 1'b0);
    wr(`LFP_A_CTRL, 32'h2);
    host(1'b0, 1'b1);
    rd(`LFP_A_FLAGS, 32'hf);
    wr(12'h040, 32'h1000);
    wr(12'h044, 32'h210);
    wr(12'h048, 32'h10);
    wr(12'h04c, 32'h1f8);
    acc(2'h0, 10'h010, 1'b1, 32'h0);
    rd(`LFP_A_ERR, 32'(`LFP_ERR_SECTOR));
    acc(2'h0, 10'h008, 1'b0, 32'h11f8);
    acc(2'h0, 10'h010, 1'b0, 32'h1200);
    rd(12'h04c, 32'h10);
    acc(2'h0, 10'h004, 1'b0, 32'h1010);
    acc(2'h3, 10'h004, 1'b1, 32'h0);
    wr(12'h054, 32'h20);
    wr(12'h05c, 32'h10);
    acc(2'h1, 10'h018, 1'b1, 32'h0);
    rd(`LFP_A_ERR, 32'(`LFP_ERR_LENGTH));
    t = $urandom;
    v = $urandom;
    wr(12'h100, t);
    wr(12'h100, v, 4'h4);
    rd(12'h100, {t[31:24], v[23:16], t[15:0]});
    rd(12'h138, 32'h0, `LFP_RESP_SLVERR);
    wr(12'h23c, v);
    rd(12'h23c, v);
    wr(`LFP_A_IEN, 32'hf);
    dq.push_back(40'h24);
    irq_pin_in <= 4'h4;
    run_wait();
    rd(`LFP_A_IEN, 32'hb);
    irq_pin_in <= 4'h0;
    repeat (8) @(posedge clk_in);
    irq_pin_in <= 4'h4;
    repeat (20) @(posedge clk_in);
    wr(`LFP_A_IEN, 32'hf);
    dq.push_back(40'h30);
    rtc_tick_pin_in <= 1'b1;
    run_wait();
    rtc_tick_pin_in <= 1'b0;
    irq_pin_in <= 4'h0;
    repeat (8) @(posedge clk_in);
    dq.push_back(40'h24);
    irq_pin_in <= 4'h4;
    run_wait();
    @(posedge clk_in);
    for (int k = 0; k < 16; k++) begin
      wo = 1'($urandom);
      lq.push_back(40'({wo, (k < 8) ? 8'h01 << k : 8'h00}));
      lut_valid_in <= 1'b1;
      lut_write_out_in <= wo;
      lut_addr_in <= 4'(k);
      @(posedge clk_in);
    end
    lut_valid_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    conclude();
  end
endmodule
